// [hdl/uaf_pkg.sv]
// Constants for the alternate address filter of the serial engine.
// Assumes an APB slave with 32-bit data and one register per word.
package uaf_pkg;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_LOCAL = 16'h7f92;
    localparam logic [15:0] IDX_STATUS = 16'h7f93;
    localparam logic [15:0] IDX_SECONDARY_ID_BIT_1 = 16'h7f99;
    localparam logic [15:0] IDX_SECONDARY_ID_BIT_2 = 16'h7f9e;
    localparam logic [15:0] IDX_SECONDARY_ID_BIT_3 = 16'h7f9f;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h7fa0;
    localparam logic [15:0] IDX_IRQ_CLR = 16'h7fa1;
    localparam logic [15:0] IDX_IRQ_EN = 16'h7fa2;

    localparam logic [ADDR_W-1:0] ADR_LOCAL = {IDX_LOCAL, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_SECONDARY_ID_BIT_1 = {IDX_SECONDARY_ID_BIT_1, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_SECONDARY_ID_BIT_2 = {IDX_SECONDARY_ID_BIT_2, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_SECONDARY_ID_BIT_3 = {IDX_SECONDARY_ID_BIT_3, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_IRQ_CLR = {IDX_IRQ_CLR, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_IRQ_EN = {IDX_IRQ_EN, 2'b00};

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int ID_W = 7;
    localparam int EP_W = 4;
    localparam int ENABLE_BIT = 7;
    localparam int ERR_BIT = 7;
    localparam logic [7:0] ID_RESET = 8'h00;
    localparam int NUM_FILT = 4;

    // Endpoint groups per filter, top nibble first: alt 3, alt 2, alt 1, local
    localparam logic [15:0] GRP_LO = {4'hc, 4'h8, 4'h0, 4'h0};
    localparam logic [15:0] GRP_HI = {4'hf, 4'hb, 4'hf, 4'h3};
    localparam logic [3:0] COMP_MASK = 4'he;

    // Interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_ACCEPT = 0;
    localparam int IRQ_ERROR = 1;

    // ----------------------------------------------------------------
    // Source of an accepted token
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_LOCAL = 3'h1,
        SRC_SECONDARY_ID_BIT_1 = 3'h3,
        SRC_SECONDARY_ID_BIT_2 = 3'h2,
        SRC_SECONDARY_ID_BIT_3 = 3'h6
    } uaf_src_t;

endpackage : uaf_pkg

// [hdl/uaf_alt_address_filter.sv]
// Token address filter of the serial engine with its APB registers.
// Assumes tokens and transaction ends come from engine logic on sys_clk.

`timescale 1ns/1ps
`default_nettype none

module uaf_alt_address_filter
    import uaf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tokenValid,
    input wire logic [ID_W-1:0] tokenAddr,
    input wire logic [EP_W-1:0] tokenEndp,
    input wire logic txnDone,
    input wire logic txnError,
    output logic endpointAccept,
    output logic [EP_W-1:0] acceptEndp,
    output uaf_src_t acceptSource,
    output logic irq
);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic setupPhase;
    logic wrEn;
    logic mapped;
    logic [31:0] rdData_d;
    logic [31:0] prdata_q;

    logic [7:0] filtId_q [NUM_FILT];
    logic errFlag_q;
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqEn_q;
    logic [IRQ_W-1:0] irqEvent;
    logic [NUM_FILT-1:0] hit;
    logic [EP_W-1:0] effEndp [NUM_FILT];

    logic endpointAccept_q;
    logic [EP_W-1:0] acceptEndp_q;
    uaf_src_t acceptSource_q;
    uaf_src_t src_d;
    logic [EP_W-1:0] endp_d;

    assign setupPhase = psel && !penable;
    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            ADR_LOCAL, ADR_STATUS, ADR_SECONDARY_ID_BIT_1, ADR_SECONDARY_ID_BIT_2, ADR_SECONDARY_ID_BIT_3,
            ADR_IRQ_STAT, ADR_IRQ_CLR, ADR_IRQ_EN: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    // ----------------------------------------------------------------
    // Address registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_FILT; i++) begin
                filtId_q[i] <= ID_RESET;
            end
        end else if (wrEn) begin
            case (paddr)
                ADR_LOCAL: begin
                    filtId_q[0] <= {1'b0, pwdata[ID_W-1:0]};
                end
                ADR_SECONDARY_ID_BIT_1: begin
                    filtId_q[1] <= pwdata[7:0];
                end
                ADR_SECONDARY_ID_BIT_2: begin
                    filtId_q[2] <= pwdata[7:0];
                end
                ADR_SECONDARY_ID_BIT_3: begin
                    filtId_q[3] <= pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Filters
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_FILT; g++) begin : gFilt
            logic enabled;
            logic [EP_W-1:0] lo;
            logic [EP_W-1:0] hi;
            // Local address is always on; alternates need bit 7
            assign enabled = (g == 0) ? 1'b1 : filtId_q[g][ENABLE_BIT];
            assign lo = GRP_LO[g*EP_W +: EP_W];
            assign hi = GRP_HI[g*EP_W +: EP_W];
            assign effEndp[g] = COMP_MASK[g] ? ~tokenEndp : tokenEndp;
            assign hit[g] = enabled
                && (filtId_q[g][ID_W-1:0] == tokenAddr)
                && (effEndp[g] >= lo) && (effEndp[g] <= hi);
        end
    endgenerate

    // Fixed priority only matters if firmware gives two enabled filters the same address
    always_comb begin
        src_d = SRC_NONE;
        endp_d = tokenEndp;
        if (hit[0]) begin
            src_d = SRC_LOCAL;
            endp_d = effEndp[0];
        end else if (hit[1]) begin
            src_d = SRC_SECONDARY_ID_BIT_1;
            endp_d = effEndp[1];
        end else if (hit[2]) begin
            src_d = SRC_SECONDARY_ID_BIT_2;
            endp_d = effEndp[2];
        end else if (hit[3]) begin
            src_d = SRC_SECONDARY_ID_BIT_3;
            endp_d = effEndp[3];
        end
    end

    // ----------------------------------------------------------------
    // Accept output
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            endpointAccept_q <= 1'b0;
            acceptEndp_q <= '0;
            acceptSource_q <= SRC_NONE;
        end else begin
            endpointAccept_q <= tokenValid && (|hit);
            if (tokenValid && (|hit)) begin
                acceptEndp_q <= endp_d;
                acceptSource_q <= src_d;
            end
        end
    end

    assign endpointAccept = endpointAccept_q;
    assign acceptEndp = acceptEndp_q;
    assign acceptSource = acceptSource_q;

    // ----------------------------------------------------------------
    // Engine status
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            errFlag_q <= 1'b0;
        end else if (txnDone) begin
            errFlag_q <= txnError;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign irqEvent[IRQ_ACCEPT] = tokenValid && (|hit);
    assign irqEvent[IRQ_ERROR] = txnDone && txnError;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irqStat_q <= '0;
        end else if (wrEn && (paddr == ADR_IRQ_CLR)) begin
            irqStat_q <= (irqStat_q & ~pwdata[IRQ_W-1:0]) | irqEvent;
        end else begin
            irqStat_q <= irqStat_q | irqEvent;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irqEn_q <= '0;
        end else if (wrEn && (paddr == ADR_IRQ_EN)) begin
            irqEn_q <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irqStat_q & irqEn_q);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        rdData_d = '0;
        case (paddr)
            ADR_LOCAL: begin
                rdData_d[7:0] = filtId_q[0];
            end
            ADR_STATUS: begin
                rdData_d[ERR_BIT] = errFlag_q;
            end
            ADR_SECONDARY_ID_BIT_1: begin
                rdData_d[7:0] = filtId_q[1];
            end
            ADR_SECONDARY_ID_BIT_2: begin
                rdData_d[7:0] = filtId_q[2];
            end
            ADR_SECONDARY_ID_BIT_3: begin
                rdData_d[7:0] = filtId_q[3];
            end
            ADR_IRQ_STAT: begin
                rdData_d[IRQ_W-1:0] = irqStat_q;
            end
            ADR_IRQ_EN: begin
                rdData_d[IRQ_W-1:0] = irqEn_q;
            end
            default: begin
                rdData_d = '0;
            end
        endcase
    end

    // Captured in the setup cycle, stands through the access cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata_q <= '0;
        end else if (setupPhase && !pwrite) begin
            prdata_q <= rdData_d;
        end
    end

    assign prdata = prdata_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_alt_complement: assert property (
        endpointAccept && (acceptSource != SRC_LOCAL)
        |-> acceptEndp == ~$past(tokenEndp)
    ) else $error("Alternate endpoint not complemented");

    a_secondary_id_bit_2_group: assert property (
        tokenValid && filtId_q[2][ENABLE_BIT]
        && (filtId_q[2][ID_W-1:0] == tokenAddr)
        && (~tokenEndp >= 4'h8) && (~tokenEndp <= 4'hb) && !hit[0] && !hit[1]
        |=> endpointAccept && (acceptSource == SRC_SECONDARY_ID_BIT_2)
    ) else $error("Alternate 2 token not accepted");

    a_secondary_id_bit_3_group: assert property (
        tokenValid && filtId_q[3][ENABLE_BIT]
        && (filtId_q[3][ID_W-1:0] == tokenAddr) && (~tokenEndp >= 4'hc)
        && !hit[0] && !hit[1] && !hit[2]
        |=> endpointAccept && (acceptSource == SRC_SECONDARY_ID_BIT_3) && (acceptEndp >= 4'hc)
    ) else $error("Alternate 3 token not accepted");

    a_disabled_quiet: assert property (
        endpointAccept && (acceptSource == SRC_SECONDARY_ID_BIT_2 || acceptSource == SRC_SECONDARY_ID_BIT_3)
        |-> ($past(filtId_q[2][ENABLE_BIT]) && acceptSource == SRC_SECONDARY_ID_BIT_2)
            || ($past(filtId_q[3][ENABLE_BIT]) && acceptSource == SRC_SECONDARY_ID_BIT_3)
    ) else $error("Disabled address produced an accept");

    a_id_write: assert property (
        psel && penable && pwrite && (paddr == ADR_SECONDARY_ID_BIT_3)
        |=> filtId_q[3] == $past(pwdata[7:0])
    ) else $error("Alternate 3 write not stored");

    a_error_flag: assert property (
        txnDone ##1 !txnDone[*2] |-> errFlag_q == $past(txnError, 2)
    ) else $error("Error flag does not follow last transaction");

    a_secondary_id_bit_1_all: assert property (
        tokenValid && filtId_q[1][ENABLE_BIT]
        && (filtId_q[1][ID_W-1:0] == tokenAddr) && !hit[0]
        |=> endpointAccept && (acceptSource == SRC_SECONDARY_ID_BIT_1)
    ) else $error("Alternate 1 token not accepted");

    a_local_group: assert property (
        endpointAccept && (acceptSource == SRC_LOCAL)
        |-> (acceptEndp <= 4'h3) && (acceptEndp == $past(tokenEndp))
    ) else $error("Local accept outside endpoints 0 to 3");

    a_accept_cause: assert property (
        endpointAccept |-> $past(tokenValid) && $past(|hit)
    ) else $error("Accept without a matching token");

    a_sticky_event: assert property (
        irqEvent[IRQ_ERROR] |=> irqStat_q[IRQ_ERROR] && (irqEn_q[IRQ_ERROR] -> irq)
    ) else $error("Error event lost from interrupt status");

    a_secondary_id_bit_2_write: assert property (
        psel && penable && pwrite && (paddr == ADR_SECONDARY_ID_BIT_2)
        |=> filtId_q[2] == $past(pwdata[7:0])
    ) else $error("Alternate 2 write not stored");

    a_status_read: assert property (
        psel && !penable && !pwrite && (paddr == ADR_STATUS)
        |=> prdata[ERR_BIT] == $past(errFlag_q)
    ) else $error("Status read does not show the error flag");

    a_refused_hold: assert property (
        tokenValid && !(|hit)
        |=> !endpointAccept && $stable(acceptEndp) && $stable(acceptSource)
    ) else $error("Refused token changed the accept outputs");

    a_local_top_bit: assert property (
        !filtId_q[0][ENABLE_BIT]
    ) else $error("Local address stored a top bit");

    a_irq_clear: assert property (
        wrEn && (paddr == ADR_IRQ_CLR) && pwdata[IRQ_ERROR] && !irqEvent[IRQ_ERROR]
        |=> !irqStat_q[IRQ_ERROR]
    ) else $error("Error status not cleared by write");

    a_accept_sticky: assert property (
        irqEvent[IRQ_ACCEPT] |=> irqStat_q[IRQ_ACCEPT]
    ) else $error("Accept event lost from interrupt status");

    a_unmapped_write: assert property (
        psel && penable && pwrite && !mapped
        |=> $stable(filtId_q[2]) && $stable(filtId_q[3])
    ) else $error("Unmapped write changed an address register");

endmodule : uaf_alt_address_filter

`default_nettype wire

// [testbench/uaf_host_model.sv]
// Host-side model that issues tokens and transaction ends.
// Assumes the filter samples these inputs on the rising sys_clk edge.
`timescale 1ns/1ps
`default_nettype none
module uaf_host_model
    import uaf_pkg::*;
(
    input wire logic sys_clk,
    output logic tokenValid,
    output logic [ID_W-1:0] tokenAddr,
    output logic [EP_W-1:0] tokenEndp,
    output logic txnDone,
    output logic txnError
);
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    initial begin
        tokenValid = 1'b0;
        tokenAddr = '0;
        tokenEndp = '0;
        txnDone = 1'b0;
        txnError = 1'b0;
    end
    task automatic token(input logic [ID_W-1:0] a, input logic [EP_W-1:0] e);
        @(posedge sys_clk);
        tokenValid <= 1'b1;
        tokenAddr <= a;
        tokenEndp <= e;
    endtask : token
    // Strobes drop low; address, endpoint and error lines show the inverse of their last value
    task automatic idle();
        @(posedge sys_clk);
        tokenValid <= 1'b0;
        tokenAddr <= ~tokenAddr;
        tokenEndp <= ~tokenEndp;
        txnDone <= 1'b0;
        txnError <= ~txnError;
    endtask : idle
    task automatic txn(input logic err);
        @(posedge sys_clk);
        txnDone <= 1'b1;
        txnError <= err;
    endtask : txn
endmodule : uaf_host_model
`default_nettype wire

// [testbench/uaf_alt_address_filter_tb.sv]
// Self-checking bench for the alternate address filter.
// Assumes zero-wait APB and the host model for token traffic.
`timescale 1ns/1ps
`default_nettype none
module uaf_alt_address_filter_tb
    import uaf_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
    logic tokenValid, txnDone, txnError, endpointAccept;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [ID_W-1:0] tokenAddr, a1, a2, a3;
    logic [EP_W-1:0] tokenEndp, acceptEndp;
    uaf_src_t acceptSource;
    logic en1, en2, en3;
    logic [33:0] apbQ[$], apbE;
    logic [6:0] tokQ[$], tokE;
    int numErrors = 0;
    int testsRun = 0;
    uaf_alt_address_filter uaf_alt_address_filter_inst (.sys_clk(sys_clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tokenValid(tokenValid),
        .tokenAddr(tokenAddr), .tokenEndp(tokenEndp), .txnDone(txnDone),
        .txnError(txnError), .endpointAccept(endpointAccept), .acceptEndp(acceptEndp),
        .acceptSource(acceptSource), .irq(irq));
    uaf_host_model uaf_host_model_inst (.sys_clk(sys_clk), .tokenValid(tokenValid),
        .tokenAddr(tokenAddr), .tokenEndp(tokenEndp), .txnDone(txnDone),
        .txnError(txnError));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : printVerdict
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        int n;
        apbQ.push_back({w, ee, ed});
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            check(32'h1, 32'h0);
            printVerdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [7:0] expAcc(input logic [ID_W-1:0] a,
                                          input logic [EP_W-1:0] e);
        logic [EP_W-1:0] ne;
        ne = ~e;
        if (a == 7'h00 && e <= 4'h3) return {1'b1, SRC_LOCAL, e};
        if (en1 && a == a1) return {1'b1, SRC_SECONDARY_ID_BIT_1, ne};
        if (en2 && a == a2 && ne[3:2] == 2'b10) return {1'b1, SRC_SECONDARY_ID_BIT_2, ne};
        if (en3 && a == a3 && ne[3:2] == 2'b11) return {1'b1, SRC_SECONDARY_ID_BIT_3, ne};
        return 8'h00;
    endfunction : expAcc
    task automatic send(input logic [ID_W-1:0] a, input logic [EP_W-1:0] e);
        logic [7:0] x;
        x = expAcc(a, e);
        if (x[7]) tokQ.push_back(x[6:0]);
        uaf_host_model_inst.token(a, e);
    endtask : send
    // ------------------------------------------------------------
    // Monitors, clock and watchdog
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1) begin
            apbE = apbQ.pop_front();
            check({31'h0, pslverr}, {31'h0, apbE[32]});
            if (!apbE[33]) check(prdata, apbE[31:0]);
        end
        if (endpointAccept === 1'b1) begin
            if (tokQ.size() == 0) check(32'h1, 32'h0);
            else begin
                tokE = tokQ.pop_front();
                check({25'h0, acceptSource, acceptEndp}, {25'h0, tokE});
            end
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        check(32'h1, 32'h0);
        printVerdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        logic [ID_W-1:0] ad[4];
        logic [31:0] d;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        {en1, en2, en3, a1, a2, a3} = '0;
        void'($urandom(32'h4820afd1));
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        apb(1'b0, ADR_SECONDARY_ID_BIT_2, 32'h0, {24'h0, ID_RESET}, 1'b0);
        apb(1'b0, ADR_SECONDARY_ID_BIT_3, 32'h0, {24'h0, ID_RESET}, 1'b0);
        apb(1'b1, 18'h00010, 32'h55, 32'h0, 1'b1);
        apb(1'b0, 18'h00010, 32'h0, 32'h0, 1'b1);
        apb(1'b1, ADR_STATUS, 32'hff, 32'h0, 1'b0);
        apb(1'b0, ADR_STATUS, 32'h0, 32'h0, 1'b0);
        apb(1'b1, ADR_LOCAL, 32'h80, 32'h0, 1'b0);
        apb(1'b0, ADR_LOCAL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, ADR_IRQ_CLR, 32'h0, 32'h0, 1'b0);
        for (i = 0; i < 8; i++) begin
            d = $urandom;
            apb(1'b1, i[0] ? ADR_SECONDARY_ID_BIT_3 : ADR_SECONDARY_ID_BIT_2, d, 32'h0, 1'b0);
            apb(1'b0, i[0] ? ADR_SECONDARY_ID_BIT_3 : ADR_SECONDARY_ID_BIT_2, 32'h0, {24'h0, d[7:0]}, 1'b0);
        end
        $display("test registers done");
        a2 = 7'($urandom_range(1, 31));
        a3 = a2 + 7'h28;
        {en2, en3} = 2'b11;
        apb(1'b1, ADR_SECONDARY_ID_BIT_2, {24'h0, en2, a2}, 32'h0, 1'b0);
        apb(1'b1, ADR_SECONDARY_ID_BIT_3, {24'h0, en3, a3}, 32'h0, 1'b0);
        ad = '{7'h00, a2, a3, a2 + 7'h50};
        for (i = 0; i < 80; i++) begin
            if (i < 32) send(ad[1 + i[0]], i[4:1]);
            else send(ad[$urandom_range(0, 3)], 4'($urandom));
        end
        uaf_host_model_inst.idle();
        {en2, en3} = 2'b00;
        apb(1'b1, ADR_SECONDARY_ID_BIT_2, {24'h0, en2, a2}, 32'h0, 1'b0);
        apb(1'b1, ADR_SECONDARY_ID_BIT_3, {24'h0, en3, a3}, 32'h0, 1'b0);
        a1 = ad[3];
        en1 = 1'b1;
        apb(1'b1, ADR_SECONDARY_ID_BIT_1, {24'h0, en1, a1}, 32'h0, 1'b0);
        apb(1'b0, ADR_SECONDARY_ID_BIT_1, 32'h0, {24'h0, en1, a1}, 1'b0);
        for (i = 0; i < 40; i++) send(ad[i % 4], i[3:0]);
        uaf_host_model_inst.idle();
        $display("test filter done");
        apb(1'b1, ADR_IRQ_CLR, 32'h3, 32'h0, 1'b0);
        apb(1'b1, ADR_IRQ_EN, 32'h1, 32'h0, 1'b0);
        uaf_host_model_inst.txn(1'b1);
        uaf_host_model_inst.idle();
        apb(1'b0, ADR_STATUS, 32'h0, 32'h80, 1'b0);
        apb(1'b0, ADR_IRQ_STAT, 32'h0, 32'h2, 1'b0);
        #1 check({31'h0, irq}, 32'h0);
        apb(1'b1, ADR_IRQ_EN, 32'h3, 32'h0, 1'b0);
        #1 check({31'h0, irq}, 32'h1);
        apb(1'b1, ADR_IRQ_CLR, 32'h2, 32'h0, 1'b0);
        #1 check({31'h0, irq}, 32'h0);
        uaf_host_model_inst.txn(1'b0);
        uaf_host_model_inst.idle();
        apb(1'b0, ADR_STATUS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, ADR_IRQ_EN, 32'h0, 32'h3, 1'b0);
        $display("test status and interrupt done");
        repeat (3) @(posedge sys_clk);
        check(tokQ.size(), 32'h0);
        printVerdict();
    end
endmodule : uaf_alt_address_filter_tb
`default_nettype wire
